/* File: pkg/pef_pkg.sv */
// Shared constants, types and pin tables for the port E function select block.
package pef_pkg;

   // ==========================================================
   // Register map (byte addresses on the APB word grid)
   localparam logic [11:0] PEF_OFS_FSEL1 = 12'h000;
   localparam logic [11:0] PEF_OFS_FSEL2 = 12'h004;
   localparam logic [11:0] PEF_OFS_DIR = 12'h008;
   localparam logic [11:0] PEF_OFS_STATUS = 12'h00c;

   // ==========================================================
   // Reset values and field layout
   localparam logic [15:0] PEF_FSEL_RST = 16'h0000;
   localparam logic [15:0] PEF_DIR_RST = 16'h0000;
   localparam int PEF_REG_W = 16;
   localparam int PEF_PIN_HI = 11;
   localparam int PEF_PIN_LO = 3;
   // Pins 11 to 8 live in bits 7:0 of the first register, pins 7 to 3 in bits 15:6 of the second.
   localparam int PEF_F1_MSB = 7;
   localparam int PEF_F1_LSB = 0;
   localparam int PEF_F2_MSB = 15;
   localparam int PEF_F2_LSB = 6;
   // Status bit positions.
   localparam int PEF_ST_DEBUG = 0;
   localparam int PEF_ST_BAD = 1;
   localparam int PEF_ST_FLASH = 2;

   // ==========================================================
   // Mode codes and alternate function kinds
   typedef enum logic [1:0] {
      PEF_M_PORT = 2'b00,
      PEF_M_TIMER = 2'b01,
      PEF_M_ALT10 = 2'b10,
      PEF_M_ALT11 = 2'b11
   } pef_mode_t;

   typedef enum logic [1:0] {
      PEF_K_IN = 2'b00,
      PEF_K_OUT = 2'b01,
      PEF_K_IO = 2'b10
   } pef_kind_t;

   // Per pin, index 11 down to 3: the one legal alternate code and its kind.
   localparam logic [11:3][1:0] PEF_ALT_CODE = {
      2'b11, 2'b10, 2'b11, 2'b10, 2'b10, 2'b10, 2'b10, 2'b10, 2'b10};
   localparam logic [11:3][1:0] PEF_ALT_KIND = {
      PEF_K_IN, PEF_K_OUT, PEF_K_IO, PEF_K_IO, PEF_K_IN, PEF_K_IO, PEF_K_OUT, PEF_K_IN, PEF_K_OUT};

   // ==========================================================
   // Peripheral bundles
   typedef struct packed {
      logic [11:3] port_out;
      logic [11:3] timer_out;
      logic serial2_transmit;
      logic serial3_transmit;
      logic serial2_clock_out;
      logic serial3_clock_out;
      logic dma1_request_acknowledge;
      logic jtag_tdo;
   } pef_to_pins_t;

   typedef struct packed {
      logic [11:3] port_in;
      logic [11:3] timer_in;
      logic serial2_receive;
      logic serial3_receive;
      logic serial2_clock_in;
      logic serial3_clock_in;
      logic jtag_tck;
   } pef_from_pins_t;

endpackage

/* File: verilog/pef_sync2.sv */
// Two-stage synchroniser for levels arriving from outside the clock domain.
module pef_sync2 import pef_pkg::*; #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s1_nxt;
   logic [W-1:0] s2_r;
   logic [W-1:0] s2_nxt;

   // ==========================================================
   // Next values; the first stage feeds only the second.
   always_comb begin
      s1_nxt = ce ? d : s1_r;
      s2_nxt = ce ? s1_r : s2_r;
   end

   // Registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
      end
   end

   assign q = s2_r;

endmodule

/* File: verilog/pef_pin_cell.sv */
// One pad's function selector: port, timer, its alternate function or a forced debug use.
module pef_pin_cell import pef_pkg::*; #(
   parameter logic [1:0] ALT_CODE = 2'b10,
   parameter logic [1:0] ALT_KIND = 2'b00,
   parameter bit FORCE_OUT = 1'b0
) (
   input wire logic [1:0] mode,
   input wire logic dir,
   input wire logic port_out,
   input wire logic timer_out,
   input wire logic alt_out,
   input wire logic force_en,
   input wire logic force_out,
   output logic drv_out,
   output logic drv_oe,
   output logic sel_port,
   output logic sel_timer,
   output logic sel_alt,
   output logic bad
);

   // ==========================================================
   // Selection; a prohibited code releases the pad rather than guess a function.
   always_comb begin
      drv_out = 1'b0;
      drv_oe = 1'b0;
      sel_port = 1'b0;
      sel_timer = 1'b0;
      sel_alt = 1'b0;
      bad = 1'b0;
      if (force_en) begin
         drv_out = force_out;
         drv_oe = FORCE_OUT;
      end else begin
         case (pef_mode_t'(mode))
            PEF_M_PORT: begin
               sel_port = 1'b1;
               drv_out = port_out;
               drv_oe = dir;
            end
            PEF_M_TIMER: begin
               sel_timer = 1'b1;
               drv_out = timer_out;
               drv_oe = dir;
            end
            default: begin
               if (mode == ALT_CODE) begin
                  sel_alt = 1'b1;
                  drv_out = alt_out;
                  drv_oe = (ALT_KIND == PEF_K_OUT) ? 1'b1 : ((ALT_KIND == PEF_K_IO) ? dir : 1'b0);
               end else begin
                  bad = 1'b1;
               end
            end
         endcase
      end
   end

endmodule

/* File: verilog/pef_top.sv */
// Port E pins 11 to 3 function multiplexer with its APB register file.
// Summary of operation
// - Pin 11: 00 port, 01 timer 3D, 11 serial 3 receive; 10 forbidden.
// - Pin 10: 00 port, 01 timer 3C, 10 serial 2 transmit; 11 forbidden.
// - Pin 9: 00 port, 01 timer 3B, 11 serial 3 clock; 10 forbidden.
// - Pin 8: 00 port, 01 timer 3A, 10 serial 2 clock; 11 forbidden.
// - Pin 7: 00 port, 01 timer 2B, 10 serial 2 receive; 11 forbidden.
// - Pin 6: 00 port, 01 timer 2A, 10 serial 3 clock; 11 forbidden.
// - Pin 5: 00 port, 01 timer 1B, 10 serial 3 transmit; 11 forbidden.
// - Pin 4: 00 port, 01 timer 1A, 10 serial 3 receive; 11 forbidden.
// - Debug pin high forces pin 4 to be the JTAG clock input.
// - Pin 3: 00 port, 01 timer 0D, 10 DMA 1 acknowledge; 11 forbidden.
// - Debug pin high forces pin 3 to be the JTAG data output.
// - Both select registers are 16-bit and readable and writable.
// - Port and timer modes take pad direction from the direction register bit.
// - Debug forcing exists only in the flash version of the device.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
module pef_top import pef_pkg::*; #(
   parameter int ADDR_W = 12,
   parameter bit FLASH_VERSION = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic debug_mode_pin,
   input wire logic [11:3] pad_in,
   output logic [11:3] pad_out,
   output logic [11:3] pad_oe,
   input wire pef_to_pins_t periph_o,
   output pef_from_pins_t periph_i
);

   logic [15:0] fsel1_r;
   logic [15:0] fsel1_nxt;
   logic [15:0] fsel2_r;
   logic [15:0] fsel2_nxt;
   logic [15:0] dir_r;
   logic [15:0] dir_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pslverr_r;
   logic pslverr_nxt;
   logic [11:3] pad_out_r;
   logic [11:3] pad_out_nxt;
   logic [11:3] pad_oe_r;
   logic [11:3] pad_oe_nxt;
   pef_from_pins_t in_r;
   pef_from_pins_t in_nxt;
   logic dbg_sync;
   logic dbg_active;
   logic [11:3] pad_sync;
   logic [11:3][1:0] pin_mode;
   logic [11:3] alt_out;
   logic [11:3] force_en;
   logic [11:3] force_out;
   logic [11:3] drv_out;
   logic [11:3] drv_oe;
   logic [11:3] sel_port;
   logic [11:3] sel_timer;
   logic [11:3] sel_alt;
   logic [11:3] bad;
   logic any_bad;
   logic [ADDR_W-1:0] word_addr;
   logic wr_en;
   logic setup;

   // ==========================================================
   // Pad and debug pin synchronisers
   pef_sync2 #(.W(1)) u_dbg_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .d(debug_mode_pin),
      .q(dbg_sync)
   );

   pef_sync2 #(.W(9)) u_pad_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .d(pad_in),
      .q(pad_sync)
   );

   // The mask-ROM and ROM-less builds tie the forced debug use off entirely.
   assign dbg_active = dbg_sync & FLASH_VERSION;

   // ==========================================================
   // APB decode; the slave answers in the first access cycle while ce is high.
   assign word_addr = {paddr[ADDR_W-1:2], 2'b00};
   assign setup = psel & ~penable & ce;
   assign wr_en = psel & penable & pwrite & ce;
   assign pready = ce;

   // Register next values; stored only at the access edge of a write.
   always_comb begin
      fsel1_nxt = fsel1_r;
      fsel2_nxt = fsel2_r;
      dir_nxt = dir_r;
      if (wr_en) begin
         case (word_addr)
            ADDR_W'(PEF_OFS_FSEL1): fsel1_nxt = pwdata[PEF_REG_W-1:0];
            ADDR_W'(PEF_OFS_FSEL2): fsel2_nxt = pwdata[PEF_REG_W-1:0];
            ADDR_W'(PEF_OFS_DIR): dir_nxt = pwdata[PEF_REG_W-1:0];
            default: begin
               fsel1_nxt = fsel1_r;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fsel1_r <= PEF_FSEL_RST;
         fsel2_r <= PEF_FSEL_RST;
         dir_r <= PEF_DIR_RST;
      end else begin
         fsel1_r <= fsel1_nxt;
         fsel2_r <= fsel2_nxt;
         dir_r <= dir_nxt;
      end
   end

   // Read data and error are latched in the setup cycle so they leave flip-flops.
   always_comb begin
      prdata_nxt = prdata_r;
      pslverr_nxt = pslverr_r;
      if (setup) begin
         pslverr_nxt = 1'b0;
         case (word_addr)
            ADDR_W'(PEF_OFS_FSEL1): prdata_nxt = {16'h0000, fsel1_r};
            ADDR_W'(PEF_OFS_FSEL2): prdata_nxt = {16'h0000, fsel2_r};
            ADDR_W'(PEF_OFS_DIR): prdata_nxt = {16'h0000, dir_r};
            ADDR_W'(PEF_OFS_STATUS): begin
               prdata_nxt = 32'h00000000;
               prdata_nxt[PEF_ST_DEBUG] = dbg_active;
               prdata_nxt[PEF_ST_BAD] = any_bad;
               prdata_nxt[PEF_ST_FLASH] = FLASH_VERSION;
            end
            default: begin
               prdata_nxt = 32'h00000000;
               pslverr_nxt = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pslverr = pslverr_r & psel & penable;

   // ==========================================================
   // Per-pin selection
   assign pin_mode = {fsel1_r[PEF_F1_MSB:PEF_F1_LSB], fsel2_r[PEF_F2_MSB:PEF_F2_LSB]};
   assign alt_out = {1'b0, periph_o.serial2_transmit, periph_o.serial3_clock_out,
                     periph_o.serial2_clock_out, 1'b0, periph_o.serial3_clock_out,
                     periph_o.serial3_transmit, 1'b0, periph_o.dma1_request_acknowledge};
   assign force_en = {7'h00, dbg_active, dbg_active};
   assign force_out = {8'h00, periph_o.jtag_tdo};

   // Each cell applies its pin's code table; direction bit steers port, timer and clock use.
   generate
      for (genvar i = PEF_PIN_LO; i <= PEF_PIN_HI; i++) begin : g_pin
         pef_pin_cell #(
            .ALT_CODE(PEF_ALT_CODE[i]),
            .ALT_KIND(PEF_ALT_KIND[i]),
            .FORCE_OUT(i == 3)
         ) u_cell (
            .mode(pin_mode[i]),
            .dir(dir_r[i]),
            .port_out(periph_o.port_out[i]),
            .timer_out(periph_o.timer_out[i]),
            .alt_out(alt_out[i]),
            .force_en(force_en[i]),
            .force_out(force_out[i]),
            .drv_out(drv_out[i]),
            .drv_oe(drv_oe[i]),
            .sel_port(sel_port[i]),
            .sel_timer(sel_timer[i]),
            .sel_alt(sel_alt[i]),
            .bad(bad[i])
         );
      end
   endgenerate

   assign any_bad = |bad;

   // ==========================================================
   // Pad drive and peripheral inputs. Receive lines idle high when no pad feeds them,
   // so a serial unit sees a quiet line instead of a false start bit.
   always_comb begin
      pad_out_nxt = ce ? drv_out : pad_out_r;
      pad_oe_nxt = ce ? drv_oe : pad_oe_r;
      in_nxt = in_r;
      if (ce) begin
         in_nxt.port_in = pad_sync;
         in_nxt.timer_in = pad_sync & sel_timer;
         in_nxt.serial3_receive = sel_alt[11] ? pad_sync[11] : (sel_alt[4] ? pad_sync[4] : 1'b1);
         in_nxt.serial2_receive = sel_alt[7] ? pad_sync[7] : 1'b1;
         in_nxt.serial3_clock_in = sel_alt[9] ? pad_sync[9] : (sel_alt[6] & pad_sync[6]);
         in_nxt.serial2_clock_in = sel_alt[8] & pad_sync[8];
         in_nxt.jtag_tck = dbg_active & pad_sync[4];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_out_r <= 9'h000;
         pad_oe_r <= 9'h000;
         in_r <= '{port_in: 9'h000, timer_in: 9'h000, serial2_receive: 1'b1,
                   serial3_receive: 1'b1, serial2_clock_in: 1'b0, serial3_clock_in: 1'b0,
                   jtag_tck: 1'b0};
      end else begin
         pad_out_r <= pad_out_nxt;
         pad_oe_r <= pad_oe_nxt;
         in_r <= in_nxt;
      end
   end

   assign pad_out = pad_out_r;
   assign pad_oe = pad_oe_r;
   assign periph_i = in_r;

   // ==========================================================
   // Assertions
   property p_pin11_rx;
      @(posedge pclk) disable iff (!presetn)
      (ce && fsel1_r[7:6] == 2'b11) |=> (!pad_oe[11] && periph_i.serial3_receive == $past(pad_sync[11]));
   endproperty
   a_pin11_rx: assert property (p_pin11_rx) else $error("pin 11 receive route wrong");

   property p_pin10_tx;
      @(posedge pclk) disable iff (!presetn)
      (ce && fsel1_r[5:4] == 2'b10) |=> (pad_oe[10] && pad_out[10] == $past(periph_o.serial2_transmit));
   endproperty
   a_pin10_tx: assert property (p_pin10_tx) else $error("pin 10 transmit route wrong");

   property p_pin9_clk;
      @(posedge pclk) disable iff (!presetn)
      (ce && fsel1_r[3:2] == 2'b11) |=> (pad_oe[9] == $past(dir_r[9]) &&
                                         pad_out[9] == $past(periph_o.serial3_clock_out));
   endproperty
   a_pin9_clk: assert property (p_pin9_clk) else $error("pin 9 clock route wrong");

   property p_pin8_clk;
      @(posedge pclk) disable iff (!presetn)
      (ce && fsel1_r[1:0] == 2'b10) |=> (pad_out[8] == $past(periph_o.serial2_clock_out) &&
                                         periph_i.serial2_clock_in == $past(pad_sync[8]));
   endproperty
   a_pin8_clk: assert property (p_pin8_clk) else $error("pin 8 clock route wrong");

   property p_pin7_rx;
      @(posedge pclk) disable iff (!presetn)
      (ce && fsel2_r[15:14] == 2'b10) |=> (!pad_oe[7] && periph_i.serial2_receive == $past(pad_sync[7]));
   endproperty
   a_pin7_rx: assert property (p_pin7_rx) else $error("pin 7 receive route wrong");

   property p_pin6_clk;
      @(posedge pclk) disable iff (!presetn)
      (ce && fsel2_r[13:12] == 2'b10) |=> pad_out[6] == $past(periph_o.serial3_clock_out);
   endproperty
   a_pin6_clk: assert property (p_pin6_clk) else $error("pin 6 clock route wrong");

   property p_pin5_tx;
      @(posedge pclk) disable iff (!presetn)
      (ce && fsel2_r[11:10] == 2'b10) |=> (pad_oe[5] && pad_out[5] == $past(periph_o.serial3_transmit));
   endproperty
   a_pin5_tx: assert property (p_pin5_tx) else $error("pin 5 transmit route wrong");

   property p_pin4_rx;
      @(posedge pclk) disable iff (!presetn)
      (ce && !dbg_active && fsel2_r[9:8] == 2'b10 && fsel1_r[7:6] != 2'b11) |=>
         periph_i.serial3_receive == $past(pad_sync[4]);
   endproperty
   a_pin4_rx: assert property (p_pin4_rx) else $error("pin 4 receive route wrong");

   property p_pin4_tck;
      @(posedge pclk) disable iff (!presetn)
      (ce && dbg_active) |=> (!pad_oe[4] && periph_i.jtag_tck == $past(pad_sync[4]));
   endproperty
   a_pin4_tck: assert property (p_pin4_tck) else $error("pin 4 not forced to debug clock");

   property p_pin3_ack;
      @(posedge pclk) disable iff (!presetn)
      (ce && !dbg_active && fsel2_r[7:6] == 2'b10) |=>
         (pad_oe[3] && pad_out[3] == $past(periph_o.dma1_request_acknowledge));
   endproperty
   a_pin3_ack: assert property (p_pin3_ack) else $error("pin 3 acknowledge route wrong");

   property p_pin3_tdo;
      @(posedge pclk) disable iff (!presetn)
      (ce && dbg_active) |=> (pad_oe[3] && pad_out[3] == $past(periph_o.jtag_tdo));
   endproperty
   a_pin3_tdo: assert property (p_pin3_tdo) else $error("pin 3 not forced to debug data out");

   property p_fsel_write;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && word_addr == ADDR_W'(PEF_OFS_FSEL2)) |=> fsel2_r == $past(pwdata[15:0]);
   endproperty
   a_fsel_write: assert property (p_fsel_write) else $error("select register write lost");

   property p_port_dir;
      @(posedge pclk) disable iff (!presetn)
      (ce && fsel1_r[1] == 1'b0) |=> pad_oe[8] == $past(dir_r[8]);
   endproperty
   a_port_dir: assert property (p_port_dir) else $error("port or timer direction wrong");

   // The debug clock reaches the peripheral side only in the flash build with the debug pin high.
   property p_no_force;
      @(posedge pclk) disable iff (!presetn)
      (ce && !(FLASH_VERSION && dbg_sync)) |=> !periph_i.jtag_tck;
   endproperty
   a_no_force: assert property (p_no_force) else $error("debug forcing in non-flash build");

endmodule

/* File: bench/test_port_e_pin_function_select.sv */
// Self-checking testbench for the port E pin function multiplexer and its APB registers.
module test_port_e_pin_function_select import pef_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Signals and stimulus tables
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic debug_mode_pin = 1'b0;
   logic [11:3] pad_in = 9'h067;
   logic [11:3] pad_out;
   logic [11:3] pad_oe;
   pef_to_pins_t periph_o;
   pef_from_pins_t periph_i;
   int n_fail = 0;
   int checks = 0;
   // Rows are port, timer, each pin's alternate code, each pin's prohibited code.
   logic [7:0] t_f1 [4] = '{8'h00, 8'h55, 8'hee, 8'hbb};
   logic [15:0] t_f2 [4] = '{16'h0000, 16'h5540, 16'haa80, 16'hffc0};
   logic [11:3] t_oe1 [4] = '{9'h1ff, 9'h1ff, 9'h0ed, 9'h000};
   logic [11:3] t_out1 [4] = '{9'h13c, 9'h0d2, 9'h0a5, 9'h000};
   logic [11:3] t_om [4] = '{9'h1ff, 9'h1ff, 9'h0ed, 9'h1ff};
   logic [11:3] t_oe0 [4] = '{9'h000, 9'h000, 9'h085, 9'h000};
   logic [3:0] t_rx [4] = '{4'hc, 4'hc, 4'h3, 4'hc};
   logic t_bad [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

   // The clock toggles every half period of 5 ns.
   always #5 pclk = ~pclk;

   pef_top #(.ADDR_W(12), .FLASH_VERSION(1'b1)) i_dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .debug_mode_pin(debug_mode_pin), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .periph_o(periph_o), .periph_i(periph_i)
   );

   // ==========================================================
   // Reporting tasks
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // ==========================================================
   // APB master tasks
   // The request is held until pready is seen high; after 50 cycles without it the test fails and stops.
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         n_fail++;
         print_verdict();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(a, 1'b1, d, r, e);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic expe, input string nm);
      logic [31:0] r;
      logic e;
      apb(a, 1'b0, 32'h0000_0000, r, e);
      chk(nm, r, exp);
      chk("pslverr", 32'(e), 32'(expe));
   endtask

   // Pads lag the registers by one edge and pad inputs by three, so five edges is ample.
   task automatic settle();
      repeat (5) @(posedge pclk);
      #1;
   endtask

   task automatic set_cfg(input logic [7:0] f1, input logic [15:0] f2, input logic [15:0] dir);
      wr(PEF_OFS_FSEL1, {24'h00_0000, f1});
      wr(PEF_OFS_FSEL2, {16'h0000, f2});
      wr(PEF_OFS_DIR, {16'h0000, dir});
      settle();
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] r;
      logic e;
      // The debug data output differs from the port value of pin 3, so forcing is visible there.
      periph_o <= '{port_out: 9'h13c, timer_out: 9'h0d2, serial2_transmit: 1'b1, serial3_transmit: 1'b1,
                    serial2_clock_out: 1'b1, serial3_clock_out: 1'b0, dma1_request_acknowledge: 1'b1,
                    jtag_tdo: 1'b1};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;

      // Reset state, 16-bit read-back and an unmapped word.
      rdchk(PEF_OFS_FSEL1, 32'h0000_0000, 1'b0, "fsel1 reset");
      rdchk(PEF_OFS_FSEL2, 32'h0000_0000, 1'b0, "fsel2 reset");
      chk("pad_oe after reset", 32'(pad_oe), 32'h0000_0000);
      wr(PEF_OFS_FSEL1, 32'hffff_a5c3);
      wr(PEF_OFS_FSEL2, 32'h1234_5a3c);
      rdchk(PEF_OFS_FSEL1, 32'h0000_a5c3, 1'b0, "fsel1 readback");
      rdchk(PEF_OFS_FSEL2, 32'h0000_5a3c, 1'b0, "fsel2 readback");
      apb(12'h010, 1'b1, 32'h0000_ffff, r, e);
      chk("unmapped write pslverr", 32'(e), 32'h0000_0001);
      rdchk(12'h010, 32'h0000_0000, 1'b1, "unmapped read");
      $display("test registers done");

      // Every mode of every pin, with the direction bits set and then cleared.
      for (int m = 0; m < 4; m++) begin
         set_cfg(t_f1[m], t_f2[m], 16'hffff);
         chk("pad_oe dir 1", 32'(pad_oe), 32'(t_oe1[m]));
         chk("pad_out dir 1", 32'(pad_out & t_om[m]), 32'(t_out1[m]));
         set_cfg(t_f1[m], t_f2[m], 16'h0000);
         chk("pad_oe dir 0", 32'(pad_oe), 32'(t_oe0[m]));
         chk("port_in", 32'(periph_i.port_in), 32'(pad_in));
         chk("timer_in", 32'(periph_i.timer_in), 32'((m == 1) ? pad_in : 9'h000));
         chk("receive lines", 32'({periph_i.serial3_receive, periph_i.serial2_receive,
             periph_i.serial3_clock_in, periph_i.serial2_clock_in}), 32'(t_rx[m]));
         apb(PEF_OFS_STATUS, 1'b0, 32'h0000_0000, r, e);
         chk("prohibited flag", 32'(r[PEF_ST_BAD]), 32'(t_bad[m]));
         $display("test mode row %0d done", m);
      end

      // Debug pin forces pins 4 and 3 over port mode, then releases them.
      set_cfg(8'h00, 16'h0000, 16'hffff);
      chk("tck idle", 32'(periph_i.jtag_tck), 32'h0000_0000);
      @(posedge pclk);
      debug_mode_pin <= 1'b1;
      settle();
      chk("pin4 oe forced", 32'(pad_oe[4]), 32'h0000_0000);
      chk("tck from pin4", 32'(periph_i.jtag_tck), 32'(pad_in[4]));
      chk("pin3 oe forced", 32'(pad_oe[3]), 32'h0000_0001);
      chk("pin3 carries tdo", 32'(pad_out[3]), 32'(periph_o.jtag_tdo));
      apb(PEF_OFS_STATUS, 1'b0, 32'h0000_0000, r, e);
      chk("debug and flash flags", 32'({r[PEF_ST_FLASH], r[PEF_ST_DEBUG]}), 32'h0000_0003);
      @(posedge pclk);
      debug_mode_pin <= 1'b0;
      settle();
      chk("pin4 back to port", 32'(pad_oe[4]), 32'h0000_0001);
      chk("pin3 back to port", 32'(pad_out[3]), 32'(periph_o.port_out[3]));
      $display("test debug forcing done");

      // Pin 4 receive and pin 6 clock input, with pins 11 and 9 left as ports so they do not win.
      @(posedge pclk);
      pad_in <= 9'h198;
      set_cfg(8'h00, 16'h2200, 16'h0000);
      chk("port_in second pattern", 32'(periph_i.port_in), 32'h0000_0198);
      chk("pin4 and pin6 inputs", 32'({periph_i.serial3_receive, periph_i.serial2_receive,
          periph_i.serial3_clock_in, periph_i.serial2_clock_in}), 32'h0000_0006);
      $display("test second receive pins done");

      // Clock enable low freezes the bus and the pads even as the debug pin rises.
      @(posedge pclk);
      ce <= 1'b0;
      debug_mode_pin <= 1'b1;
      settle();
      chk("pready while frozen", 32'(pready), 32'h0000_0000);
      chk("pin3 oe frozen", 32'(pad_oe[3]), 32'h0000_0000);
      @(posedge pclk);
      ce <= 1'b1;
      settle();
      chk("pin3 oe forced after thaw", 32'(pad_oe[3]), 32'h0000_0001);
      chk("pin3 tdo after thaw", 32'(pad_out[3]), 32'h0000_0001);
      $display("test clock enable done");
      print_verdict();
   end
endmodule
